// ==== src/dipin_cfg.svh ====
// Constants for the debounced isolated input port
`ifndef DIPIN_CFG_SVH
`define DIPIN_CFG_SVH
`define DIPIN_CLK_HZ        50000000
`define DIPIN_DELAY_SHORT_US 500
`define DIPIN_DELAY_MID_US   5000
`define DIPIN_DELAY_LONG_US  10000
`define DIPIN_STABLE_TICKS  3'h4
`define DIPIN_RT_SHORT      2'h1
`define DIPIN_RT_MID        2'h2
`define DIPIN_RT_LONG       2'h3
`define DIPIN_RT_RESET      2'h2
`define DIPIN_RT_NONE       2'h0
`define DIPIN_LINE_EDGE     15
`define DIPIN_VEC_LOW_MASK  8'hf8
`endif

// ==== src/dipin_pkg.sv ====
// Types for the debounced isolated input port
package dipin_pkg;
    typedef struct packed {
        logic [1:0] resp_time;
        logic       low_range_select;
    } dipin_mode_t;

    typedef struct packed {
        logic irq_enable_bit;
        logic rise_edge_enable;
        logic fall_edge_enable;
    } dipin_ctrl_t;
endpackage

// ==== src/dipin_port.sv ====
// Debounced isolated sixteen-line input port
`timescale 1ns/1ps
`default_nettype none
`include "dipin_cfg.svh"

// Overview of operation
// - Buffer shows all sixteen clean input levels
// - Output follows after four stable tick periods
// - Mode code sets total bounce delay
// - Reset selects the five millisecond delay
// - Bit three selects low input range
// - Reset clears low range select
// - Rising line 15 sets request flag
// - Falling line 15 sets request flag
// - Interrupt requested only while enable set
// - Respond to own address, give vector
// - Host writes one clears; test sets
// - Line 15 interrupt uses vector low zero
// - Codes one to three valid, zero not
module dipin_port #(
    parameter int          WIDTH       = 16,
    parameter int unsigned SHORT_TICK  = (`DIPIN_CLK_HZ / 1000000) * `DIPIN_DELAY_SHORT_US / 4,
    parameter int unsigned MID_TICK    = (`DIPIN_CLK_HZ / 1000000) * `DIPIN_DELAY_MID_US / 4,
    parameter int unsigned LONG_TICK   = (`DIPIN_CLK_HZ / 1000000) * `DIPIN_DELAY_LONG_US / 4
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Field inputs
    input  wire logic [WIDTH-1:0]      field_in,
    // Configuration
    input  wire dipin_pkg::dipin_mode_t mode_in,
    input  wire logic                  mode_we,
    input  wire dipin_pkg::dipin_ctrl_t ctrl_in,
    input  wire logic                  ctrl_we,
    input  wire logic                  flag_clear,
    input  wire logic                  request_test_bit,
    // Bus select and vector
    input  wire logic [7:0]            vector_base,
    input  wire logic                  bus_sel,
    input  wire logic                  irq_ack,
    // Status
    output logic [WIDTH-1:0]           input_buffer,
    output dipin_pkg::dipin_mode_t     mode_out,
    output dipin_pkg::dipin_ctrl_t     ctrl_out,
    output logic                       edge_request_flag,
    output logic                       low_range_select,
    output logic                       irq_req,
    output logic [7:0]                 vector_out,
    output logic                       vector_valid
);
    import dipin_pkg::*;

    function automatic logic [31:0] tick_len(input logic [1:0] rt);
        if (rt == `DIPIN_RT_SHORT) begin
            tick_len = SHORT_TICK;
        end else if (rt == `DIPIN_RT_LONG) begin
            tick_len = LONG_TICK;
        end else begin
            tick_len = MID_TICK;
        end
    endfunction

    // Three-stage input synchroniser
    logic [WIDTH-1:0] s1_q, s2_q, s3_q;
    logic [WIDTH-1:0] agree;
    assign agree = ~(s2_q ^ s3_q);

    // Configuration state
    dipin_mode_t mode_q, mode_d;
    dipin_ctrl_t ctrl_q, ctrl_d;
    logic        flag_q, flag_d;
    logic [31:0] div_q, div_d;
    logic        tick;
    logic [WIDTH-1:0] clean_q, clean_d;
    logic [2:0]  cnt_q [WIDTH];
    logic [2:0]  cnt_d [WIDTH];
    logic        prev15_q, prev15_d;
    logic        rise, fall;
    logic [7:0]  vec_q, vec_d;
    logic        vval_q, vval_d;

    always_comb begin
        mode_d = mode_q;
        if (mode_we && bus_sel && mode_in.resp_time != `DIPIN_RT_NONE) begin
            mode_d = mode_in;
        end else if (mode_we && bus_sel) begin
            mode_d.low_range_select = mode_in.low_range_select;
        end
        ctrl_d = ctrl_q;
        if (ctrl_we && bus_sel) begin
            ctrl_d = ctrl_in;
        end
    end

    // Debounce tick divider
    always_comb begin
        tick  = (div_q >= tick_len(mode_q.resp_time) - 32'h1);
        div_d = tick ? 32'h0 : div_q + 32'h1;
    end

    // Debounce: level must stay for four ticks
    always_comb begin
        clean_d = clean_q;
        for (int i = 0; i < WIDTH; i++) begin
            cnt_d[i] = cnt_q[i];
            if (agree[i] && s3_q[i] == clean_q[i]) begin
                cnt_d[i] = 3'h0;
            end else if (agree[i] && tick) begin
                if (cnt_q[i] == `DIPIN_STABLE_TICKS - 3'h1) begin
                    clean_d[i] = s3_q[i];
                    cnt_d[i]   = 3'h0;
                end else begin
                    cnt_d[i] = cnt_q[i] + 3'h1;
                end
            end else if (!agree[i]) begin
                cnt_d[i] = 3'h0;
            end
        end
    end

    // Edge capture on line 15
    always_comb begin
        prev15_d = clean_q[`DIPIN_LINE_EDGE];
        rise = clean_q[`DIPIN_LINE_EDGE] & ~prev15_q & ctrl_q.rise_edge_enable;
        fall = ~clean_q[`DIPIN_LINE_EDGE] & prev15_q & ctrl_q.fall_edge_enable;
        flag_d = flag_q;
        if (flag_clear && bus_sel) begin
            flag_d = 1'b0;
        end
        if (rise || fall || (request_test_bit && bus_sel)) begin
            flag_d = 1'b1;
        end
    end

    // Vector supply on acknowledge
    always_comb begin
        vval_d = irq_ack && irq_req;
        vec_d  = vval_d ? (vector_base & `DIPIN_VEC_LOW_MASK) : vec_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            mode_q   <= '{resp_time: `DIPIN_RT_RESET, low_range_select: 1'b0};
            ctrl_q   <= '0;
            flag_q   <= 1'b0;
            div_q    <= 32'h0;
            clean_q  <= '0;
            for (int i = 0; i < WIDTH; i++) begin
                cnt_q[i] <= 3'h0;
            end
            prev15_q <= 1'b0;
            vec_q    <= 8'h0;
            vval_q   <= 1'b0;
        end else begin
            s1_q     <= field_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            mode_q   <= mode_d;
            ctrl_q   <= ctrl_d;
            flag_q   <= flag_d;
            div_q    <= div_d;
            clean_q  <= clean_d;
            cnt_q    <= cnt_d;
            prev15_q <= prev15_d;
            vec_q    <= vec_d;
            vval_q   <= vval_d;
        end
    end

    assign input_buffer      = clean_q;
    assign mode_out          = mode_q;
    assign ctrl_out          = ctrl_q;
    assign edge_request_flag = flag_q;
    assign low_range_select  = mode_q.low_range_select;
    assign irq_req           = flag_q & ctrl_q.irq_enable_bit;
    assign vector_out        = vec_q;
    assign vector_valid      = vval_q;

    a_flag_rise: assert property (@(posedge clk) disable iff (rst)
        rise |=> flag_q) else $error("rising edge did not set flag");
    a_flag_fall: assert property (@(posedge clk) disable iff (rst)
        fall |=> flag_q) else $error("falling edge did not set flag");
    a_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irq_req |-> (flag_q && ctrl_q.irq_enable_bit)) else $error("irq without enable");
    a_clean_stable: assert property (@(posedge clk) disable iff (rst)
        $changed(clean_q) |-> $past(tick)) else $error("clean changed off tick");
    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        (flag_clear && bus_sel && rise) |=> flag_q) else $error("clear beat edge");
    a_clear_flag: assert property (@(posedge clk) disable iff (rst)
        (flag_clear && bus_sel && !rise && !fall && !request_test_bit) |=> !flag_q)
        else $error("flag not cleared");
    a_vector_low: assert property (@(posedge clk) disable iff (rst)
        vector_valid |-> vector_out[2:0] == 3'h0) else $error("vector low digit nonzero");
    a_rt_valid: assert property (@(posedge clk) disable iff (rst)
        mode_q.resp_time != `DIPIN_RT_NONE) else $error("response code zero");
    a_edge_once: assert property (@(posedge clk) disable iff (rst)
        rise |=> !rise) else $error("edge counted twice");

    // Bus, flag and vector checks
    a_foreign_ignored: assert property (@(posedge clk) disable iff (rst)
        !bus_sel |=> (mode_q == $past(mode_q) && ctrl_q == $past(ctrl_q)))
        else $error("write taken without select");
    a_lls_write: assert property (@(posedge clk) disable iff (rst)
        (mode_we && bus_sel) |=> low_range_select == $past(mode_in.low_range_select))
        else $error("low range select not written");
    a_test_sets: assert property (@(posedge clk) disable iff (rst)
        (request_test_bit && bus_sel) |=> flag_q)
        else $error("test bit did not set flag");
    a_flag_holds: assert property (@(posedge clk) disable iff (rst)
        (flag_q && !(flag_clear && bus_sel)) |=> flag_q)
        else $error("flag dropped without clear");
    a_no_spurious: assert property (@(posedge clk) disable iff (rst)
        (!flag_q && !rise && !fall && !(request_test_bit && bus_sel)) |=> !flag_q)
        else $error("flag set without cause");
    a_vector_ack: assert property (@(posedge clk) disable iff (rst)
        (irq_ack && irq_req) |=> (vector_valid &&
            vector_out == ($past(vector_base) & `DIPIN_VEC_LOW_MASK)))
        else $error("vector not supplied on acknowledge");
endmodule // dipin_port
`default_nettype wire

// ==== test/dipin_host.sv ====
// Host side model that drives the port's configuration strobes
`timescale 1ns/1ps
`default_nettype none
module dipin_host (
    // Clock
    input  wire logic                  clk,
    // Bus strobes
    output var dipin_pkg::dipin_mode_t mode_in,
    output var dipin_pkg::dipin_ctrl_t ctrl_in,
    output var logic [4:0]             strb,
    output var logic                   bus_sel
);
    import dipin_pkg::*;
    initial begin
        {mode_in, ctrl_in, strb, bus_sel} = '0;
    end
    // One access: strobes are mode, ctrl, clear, test, ack
    task automatic strobe(input logic [4:0] w, input logic sel, input logic [5:0] d);
        @(posedge clk);
        {mode_in, ctrl_in} <= d;
        strb <= w;
        bus_sel <= sel;
        @(posedge clk);
        {mode_in, ctrl_in} <= ~d;
        strb <= '0;
        bus_sel <= 1'b0;
    endtask
endmodule // dipin_host
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the debounced input port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dipin_pkg::*;
    logic clk = 0, rst = 1, bus_sel, ef, lr, irq, vv;
    logic [15:0] field_in = '0, ib, w;
    logic [7:0] vector_base = '0, vo, seen = '0;
    logic [4:0] s;
    dipin_mode_t mi, mo;
    dipin_ctrl_t ci, co;
    int mismatches = 0, comparisons = 0, cnt;
    logic [31:0] seed = 32'hec3916c4;
    dipin_host host_u (.clk(clk), .mode_in(mi), .ctrl_in(ci), .strb(s), .bus_sel(bus_sel));
    dipin_port #(.SHORT_TICK(4), .MID_TICK(8), .LONG_TICK(16)) dut_u (.clk(clk), .rst(rst),
        .field_in(field_in), .mode_in(mi), .mode_we(s[4]), .ctrl_in(ci), .ctrl_we(s[3]),
        .flag_clear(s[2]), .request_test_bit(s[1]), .vector_base(vector_base),
        .bus_sel(bus_sel), .irq_ack(s[0]), .input_buffer(ib), .mode_out(mo), .ctrl_out(co),
        .edge_request_flag(ef), .low_range_select(lr), .irq_req(irq), .vector_out(vo),
        .vector_valid(vv));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (vv === 1'b1) seen <= vo;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int tk(input logic [1:0] c);
        return c == 2'h1 ? 4 : c == 2'h2 ? 8 : 16;
    endfunction
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic op(input logic [4:0] st, input logic sel, input logic [5:0] d);
        host_u.strobe(st, sel, d);
        #1;
    endtask
    task automatic settle(input logic [15:0] v);
        @(posedge clk);
        field_in <= v;
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (ib !== v && cnt < 200);
    endtask
    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        vector_base <= 8'(rnd()) | 8'h8f;
        @(posedge clk);
        #1;
        chk(mo.resp_time === 2'h2 && lr === 1'b0 && ef === 1'b0 && irq === 1'b0, "reset");
        op(5'h10, 1, 6'b001000);
        chk(mo.resp_time === 2'h2 && lr === 1'b1, "code zero");
        op(5'h10, 0, 6'b110000);
        chk(mo === 3'b101, "foreign write");
        for (int c = 1; c < 4; c++) begin
            op(5'h10, 1, {c[1:0], 4'h0});
            chk(lr === 1'b0 && mo.resp_time === c[1:0], "mode");
            w = ib ^ (16'(rnd()) | 16'h1);
            settle(w);
            chk(ib === w && cnt >= 3 * tk(c) && cnt <= 5 * tk(c) + 6, "debounce");
        end
        for (int e = 0; e < 4; e++) begin
            op(5'h08, 1, {4'h1, e[1:0]});
            chk(co === {1'b1, e[1:0]}, "ctrl");
            op(5'h04, 1, '0);
            w = ib ^ 16'h8000;
            settle(w);
            repeat (2) @(posedge clk);
            #1;
            chk(ef === (w[15] ? e[1] : e[0]) && irq === ef, "edge");
        end
        op(5'h08, 1, 6'h0);
        op(5'h02, 1, 6'h0);
        chk(ef === 1'b1 && irq === 1'b0, "masked");
        op(5'h08, 1, 6'h4);
        chk(irq === 1'b1, "irq");
        op(5'h01, 1, 6'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(seen === (vector_base & 8'hf8) && vv === 1'b0, "vector");
        op(5'h06, 1, 6'h0);
        chk(ef === 1'b1, "set wins");
        op(5'h04, 1, 6'h0);
        chk(ef === 1'b0 && irq === 1'b0, "clear");
        close_out();
    end
endmodule // testbench
`default_nettype wire
